// ### hdl/lsct_ctrl.sv
// LED select and compliance test register bank behind an AHB-Lite slave.
// Assumes status inputs come from logic on hclk; only the strap is asynchronous.
//
// Local design decision: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "lsct_defines.svh"

module lsct_ctrl
  import lsct_pkg::*;
#(
  parameter int STRETCH_CYCLES = `LSCT_STRETCH_CYC,
  parameter int BLINK_CYCLES   = `LSCT_BLINK_CYC
) (
  input  wire logic        hclk,               // Bus clock, 125 MHz
  input  wire logic        hresetn,            // Async reset, active low
  input  wire logic        hsel,               // Slave select
  input  wire logic [31:0] haddr,              // Byte address
  input  wire logic [1:0]  htrans,             // Transfer type
  input  wire logic        hwrite,             // Write when high
  input  wire logic [2:0]  hsize,              // Word only
  input  wire logic [31:0] hwdata,             // Write data
  input  wire logic        hready,             // Bus ready
  output logic      [31:0] hrdata,             // Read data
  output logic             hreadyout,          // Slave ready
  output logic             hresp,              // Always OKAY
  input  wire logic        led_strap,          // Polarity strap pin
  input  wire logic        link_good,          // Link up
  input  wire logic        tx_act,             // Transmit activity
  input  wire logic        rx_act,             // Receive activity
  input  wire logic        collision,          // Collision seen
  input  wire logic        speed100,           // Running 100 Mb/s
  input  wire logic        full_duplex,        // Full duplex
  input  wire logic        lpi_mode,           // Low-power idle
  input  wire logic        mii_err,            // MII tx or rx error
  input  wire logic        prbs_err,           // One-cycle checker error
  output logic             collision_pin_led,  // Collision pin level
  output logic             first_led_pin,      // First LED pin level
  output logic             tp10_en,            // 10 Mb/s pattern on
  output logic      [3:0]  tp10_sel,           // 10 Mb/s pattern code
  output logic             tp100_en,           // 100 Mb/s test on
  output logic      [4:0]  tp100_zeros         // Zeros after each one
);

  // Stretch and blink counters are 16 bits wide; a zero count would wrap the blink reload to 65535
  if (STRETCH_CYCLES < 1 || STRETCH_CYCLES > 65535 || BLINK_CYCLES < 1 ||
      BLINK_CYCLES > 65535) begin : g_count_check
    $error("lsct_ctrl: counts must lie in 1..65535");
  end

  lsct_state_t st;
  lsct_state_t nx;
  lsct_src_t   src;
  logic        act;
  logic        led_on;
  logic        level;
  logic        addr_ok;
  logic [15:0] rval;

  assign src = lsct_src_t'(st.led_ctl[`LSCT_SRC_HI:`LSCT_SRC_LO]);
  assign act = tx_act | rx_act;
  assign addr_ok = (haddr[31:14] == 18'h00000) && (haddr[1:0] == 2'h0);

  always_comb begin
    nx = st;
    rval = 16'h0000;
    led_on = 1'b0;
    level = 1'b0;

    // Strap sampled only after two sync stages settle
    nx.sync1 = led_strap;
    nx.sync2 = st.sync1;
    if (!st.strap_done) begin
      nx.strap_cnt = st.strap_cnt + 2'h1;
      if (st.strap_cnt == `LSCT_STRAP_WAIT) begin
        nx.led_ctl[`LSCT_POL_BIT] = ~st.sync2;
        nx.strap_done = 1'b1;
      end
    end

    // Data phase of a write; software overrides a same-cycle strap load
    if (st.dp_wr) begin
      case (st.dp_idx)
        `LSCT_IDX_LEDCR: nx.led_ctl = hwdata[15:0];
        `LSCT_IDX_COMP:  nx.comp = hwdata[15:0];
        `LSCT_IDX_EXT:   nx.ext = hwdata[15:0];
        `LSCT_IDX_ERRCNT: begin
          nx.ipg = hwdata[7:0];
          if (hwdata[`LSCT_ERR_LOCK_BIT]) begin
            nx.err_snap = st.err_cnt;
            nx.err_cnt = 8'h00;
            nx.prbs_latch = 1'b0;
          end
        end
        default: ;
      endcase
    end

    if (st.dp_rd && st.dp_idx == `LSCT_IDX_BASIC) begin
      nx.lost_latch = 1'b0;
    end
    nx.link_prev = link_good;
    if (src == LSCT_SRC_LOST && st.link_prev && !link_good) begin
      nx.lost_latch = 1'b1;
    end
    // Error latch and count, set wins
    if (prbs_err) begin
      if (nx.err_cnt != `LSCT_ERR_MAX) begin
        nx.err_cnt = nx.err_cnt + 8'h01;
      end
      if (src == LSCT_SRC_PRBS) begin
        nx.prbs_latch = 1'b1;
      end
    end

    // Activity stretch and blink timebase
    if (act) begin
      nx.stretch_cnt = STRETCH_CYCLES[15:0];
    end else if (st.stretch_cnt != 16'h0000) begin
      nx.stretch_cnt = st.stretch_cnt - 16'h0001;
    end
    if (st.blink_cnt == 16'h0000) begin
      nx.blink_cnt = BLINK_CYCLES[15:0] - 16'h0001;
      nx.blink_ph = ~st.blink_ph;
    end else begin
      nx.blink_cnt = st.blink_cnt - 16'h0001;
    end

    case (src)
      LSCT_SRC_LINK:    led_on = link_good;
      LSCT_SRC_ACT:     led_on = act;
      LSCT_SRC_TXACT:   led_on = tx_act;
      LSCT_SRC_RXACT:   led_on = rx_act;
      LSCT_SRC_COL:     led_on = collision;
      LSCT_SRC_SPD100:  led_on = link_good & speed100;
      LSCT_SRC_SPD10:   led_on = link_good & ~speed100;
      LSCT_SRC_FDX:     led_on = link_good & full_duplex;
      LSCT_SRC_BLINK:   led_on = link_good & ((st.stretch_cnt == 16'h0000) | st.blink_ph);
      LSCT_SRC_STRETCH: led_on = act | (st.stretch_cnt != 16'h0000);
      LSCT_SRC_MIILINK: led_on = link_good & speed100 & full_duplex;
      LSCT_SRC_LPI:     led_on = lpi_mode;
      LSCT_SRC_MIIERR:  led_on = mii_err;
      LSCT_SRC_LOST:    led_on = st.lost_latch;
      LSCT_SRC_PRBS:    led_on = st.prbs_latch;
      default:          led_on = 1'b0;
    endcase
    level = ~(led_on ^ st.led_ctl[`LSCT_POL_BIT]);
    // Pin routing; reserved routes drive nothing
    nx.led_col = (st.led_ctl[`LSCT_ROUTE_HI:`LSCT_ROUTE_LO] == `LSCT_ROUTE_COL) & level;
    nx.led_first = (st.led_ctl[`LSCT_ROUTE_HI:`LSCT_ROUTE_LO] == `LSCT_ROUTE_FIRST) & level;

    // 10 Mb/s pattern; codes above 12 send nothing
    nx.tp10_en = st.comp[`LSCT_TP10_EN_BIT] && (st.comp[3:0] <= `LSCT_TP10_LAST);
    nx.tp10_sel = st.comp[3:0];
    nx.tp100_en = st.ext[`LSCT_EXT_EN_BIT];
    // Pattern taken only on the enable's rising edge
    if (st.ext[`LSCT_EXT_EN_BIT] && !st.tp100_en) begin
      nx.tp100_zeros = {st.ext[`LSCT_EXT_MSB_BIT], st.comp[3:0]};
    end

    // Address phase; unmapped or misaligned reads return zero
    nx.dp_wr = hsel && htrans[1] && hready && hwrite && addr_ok;
    nx.dp_rd = hsel && htrans[1] && hready && !hwrite && addr_ok;
    nx.dp_idx = haddr[13:2];
    // Read from the post-write view so back-to-back write then read is coherent
    if (nx.dp_rd) begin
      case (nx.dp_idx)
        `LSCT_IDX_LEDCR: rval = nx.led_ctl;
        `LSCT_IDX_COMP:  rval = nx.comp;
        `LSCT_IDX_EXT:   rval = nx.ext;
        `LSCT_IDX_ERRCNT: rval = {nx.err_snap, nx.ipg};
        default:         rval = 16'h0000;
      endcase
    end
    nx.hrdata = {16'h0000, rval};
    nx.hreadyout = 1'b1;
    nx.hresp = 1'b0;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st <= '0;
      st.led_ctl <= `LSCT_LEDCR_RESET;
      st.comp <= `LSCT_COMP_RESET;
      st.ext <= `LSCT_EXT_RESET;
      st.ipg <= `LSCT_IPG_RESET;
      st.hreadyout <= 1'b1;
    end else begin
      st <= nx;
    end
  end

  assign hrdata = st.hrdata;
  assign hreadyout = st.hreadyout;
  assign hresp = st.hresp;
  assign collision_pin_led = st.led_col;
  assign first_led_pin = st.led_first;
  assign tp10_en = st.tp10_en;
  assign tp10_sel = st.tp10_sel;
  assign tp100_en = st.tp100_en;
  assign tp100_zeros = st.tp100_zeros;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_strap_polarity: assert property (
    $rose(st.strap_done) && !$past(st.dp_wr) |-> st.led_ctl[9] == !$past(st.sync2))
    else $error("polarity not loaded from strap");

  a_link_source: assert property (
    src == LSCT_SRC_LINK && st.led_ctl[1:0] == 2'h0 |=>
      st.led_col == ($past(link_good) ~^ $past(st.led_ctl[9])))
    else $error("link source level wrong on collision pin");

  a_speed_source: assert property (
    src == LSCT_SRC_SPD100 && st.led_ctl[9] && st.led_ctl[1:0] == 2'h3 |=>
      first_led_pin == ($past(link_good) && $past(speed100)))
    else $error("speed source level wrong");

  a_reserved_dark: assert property (
    src == LSCT_SRC_RSVD && st.led_ctl[1:0] == 2'h3 |=> first_led_pin == !$past(st.led_ctl[9]))
    else $error("reserved source lit the LED");

  a_lost_hold: assert property (
    st.lost_latch && !(st.dp_rd && st.dp_idx == 12'h001) |=> st.lost_latch)
    else $error("link-lost latch released without read");

  a_prbs_latch: assert property (
    prbs_err && src == LSCT_SRC_PRBS |=> st.prbs_latch [*2] or
      (st.prbs_latch ##1 1'b1))
    else $error("checker error did not latch LED");

  a_route_off: assert property (
    st.led_ctl[1:0] != 2'h3 |=> !first_led_pin)
    else $error("first LED pin driven while not routed");

  a_tp10_gate: assert property (
    !st.comp[4] || st.comp[3:0] > 4'hc |=> !tp10_en)
    else $error("10 Mb/s pattern sent while disabled or reserved");

  a_tp100_keep: assert property (
    st.tp100_en && st.ext[4] |=> $stable(tp100_zeros) && tp100_en)
    else $error("100 Mb/s pattern changed without re-enable");

  a_count_clear: assert property (
    st.dp_wr && st.dp_idx == 12'h01b && hwdata[15] && !prbs_err |=>
      st.err_cnt == 8'h00 && st.err_snap == $past(st.err_cnt))
    else $error("error counter not locked and cleared");

endmodule

// ### common/lsct_defines.svh
// Constants for the LED select and compliance test register bank.
// Assumes a 125 MHz bus clock; offsets are register indices, byte address = 4 * index.
`ifndef LSCT_DEFINES_SVH
`define LSCT_DEFINES_SVH

`define LSCT_IDX_BASIC     12'h001
`define LSCT_IDX_ERRCNT    12'h01b
`define LSCT_IDX_LEDCR     12'h025
`define LSCT_IDX_COMP      12'h027
`define LSCT_IDX_EXT       12'h428

`define LSCT_POL_BIT       9
`define LSCT_SRC_HI        6
`define LSCT_SRC_LO        3
`define LSCT_ROUTE_HI      1
`define LSCT_ROUTE_LO      0
`define LSCT_TP10_EN_BIT   4
`define LSCT_EXT_EN_BIT    4
`define LSCT_EXT_MSB_BIT   5
`define LSCT_ERR_LOCK_BIT  15

`define LSCT_ROUTE_COL     2'h0
`define LSCT_ROUTE_FIRST   2'h3
`define LSCT_TP10_LAST     4'hc
`define LSCT_IPG_RESET     8'h7d
`define LSCT_LEDCR_RESET   16'h0000
`define LSCT_COMP_RESET    16'h0000
`define LSCT_EXT_RESET     16'h0000
`define LSCT_ERR_MAX       8'hff
`define LSCT_STRAP_WAIT    2'h2

`define LSCT_CLK_PERIOD_PS 8000
`define LSCT_STRETCH_US    20
`define LSCT_BLINK_US      20
`define LSCT_STRETCH_CYC   ((`LSCT_STRETCH_US * 1000000) / `LSCT_CLK_PERIOD_PS)
`define LSCT_BLINK_CYC     ((`LSCT_BLINK_US * 1000000) / `LSCT_CLK_PERIOD_PS)

`endif

// ### common/lsct_pkg.sv
// Types for the LED select and compliance test register bank.
// Assumes lsct_defines.svh is on the include path.
package lsct_pkg;

  typedef enum logic [3:0] {
    LSCT_SRC_LINK    = 4'h0,
    LSCT_SRC_ACT     = 4'h1,
    LSCT_SRC_TXACT   = 4'h2,
    LSCT_SRC_RXACT   = 4'h3,
    LSCT_SRC_COL     = 4'h4,
    LSCT_SRC_SPD100  = 4'h5,
    LSCT_SRC_SPD10   = 4'h6,
    LSCT_SRC_FDX     = 4'h7,
    LSCT_SRC_BLINK   = 4'h8,
    LSCT_SRC_STRETCH = 4'h9,
    LSCT_SRC_MIILINK = 4'ha,
    LSCT_SRC_LPI     = 4'hb,
    LSCT_SRC_MIIERR  = 4'hc,
    LSCT_SRC_LOST    = 4'hd,
    LSCT_SRC_PRBS    = 4'he,
    LSCT_SRC_RSVD    = 4'hf
  } lsct_src_t;

  typedef struct packed {
    logic        dp_wr;
    logic        dp_rd;
    logic [11:0] dp_idx;
    logic [15:0] led_ctl;
    logic [15:0] comp;
    logic [15:0] ext;
    logic [7:0]  ipg;
    logic [7:0]  err_cnt;
    logic [7:0]  err_snap;
    logic        lost_latch;
    logic        prbs_latch;
    logic        link_prev;
    logic [15:0] stretch_cnt;
    logic [15:0] blink_cnt;
    logic        blink_ph;
    logic        sync1;
    logic        sync2;
    logic [1:0]  strap_cnt;
    logic        strap_done;
    logic        led_col;
    logic        led_first;
    logic        tp10_en;
    logic [3:0]  tp10_sel;
    logic        tp100_en;
    logic [4:0]  tp100_zeros;
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } lsct_state_t;

endpackage

// ### sim/lsct_phy_model.sv
// Partner model: line-side status sources that feed the LED logic.
// Assumes the bench changes stat and fire just after rising edges of hclk.
`timescale 1ns/1ps
module lsct_phy_model (
  input  wire logic [7:0] stat,         // Status vector from the bench
  input  wire logic       fire,         // One-cycle checker error
  output logic            link_good,    // Link up
  output logic            tx_act,       // Transmit activity
  output logic            rx_act,       // Receive activity
  output logic            collision,    // Collision
  output logic            speed100,     // Forced 100 Mb/s
  output logic            full_duplex,  // Full duplex
  output logic            lpi_mode,     // Low-power idle
  output logic            mii_err,      // MII error
  output logic            prbs_err      // Checker error pulse
);
  assign {mii_err, lpi_mode, full_duplex, speed100} = stat[7:4];
  assign {collision, rx_act, tx_act, link_good} = stat[3:0];
  assign prbs_err = fire;
endmodule

// ### sim/lsct_tb.sv
// Self-checking bench for the LED select and compliance register bank.
// Assumes a single AHB-Lite slave whose hreadyout is the bus's hready.
`timescale 1ns/1ps
`include "lsct_defines.svh"
module testbench;
  import lsct_pkg::*;
  logic        hclk = 1'h0;
  logic        hresetn = 1'h0;
  logic        hsel = 1'h0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic [7:0]  stat = 8'h0;
  logic        fire = 1'h0;
  logic        strap = 1'h1;
  logic        lg, ta, ra, co, sp, fd, lp, me, pe;
  logic        col_led, first_led, tp10_en, tp100_en;
  logic [3:0]  tp10_sel;
  logic [4:0]  tp100_zeros;
  logic [15:0] led_m;
  logic [31:0] rd, rnd;
  logic [11:0] ids [3];
  int          bad_count = 0;
  int          compares = 0;
  integer      seed = 32'h693f;
  int          lit_n;
  localparam int STR = 4;
  localparam int BLK = 4;

  always #4 hclk = ~hclk;

  lsct_ctrl #(.STRETCH_CYCLES(STR), .BLINK_CYCLES(BLK)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .led_strap(strap), .link_good(lg), .tx_act(ta),
    .rx_act(ra), .collision(co), .speed100(sp), .full_duplex(fd), .lpi_mode(lp),
    .mii_err(me), .prbs_err(pe), .collision_pin_led(col_led), .first_led_pin(first_led),
    .tp10_en(tp10_en), .tp10_sel(tp10_sel), .tp100_en(tp100_en), .tp100_zeros(tp100_zeros));

  lsct_phy_model u_phy (.stat(stat), .fire(fire), .link_good(lg), .tx_act(ta), .rx_act(ra),
    .collision(co), .speed100(sp), .full_duplex(fd), .lpi_mode(lp), .mii_err(me),
    .prbs_err(pe));

  task end_sim;
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // Bounded wait for hready, sampled at a rising edge
  task waitrdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'h1 && n < 50);
    if (hreadyout !== 1'h1) begin
      bad_count++;
      end_sim();
    end
  endtask

  task bus(input logic w, input logic [11:0] idx, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {18'h0, idx, 2'h0};
    waitrdy();
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= wd;
    waitrdy();
    rd = hrdata;
    chk("hresp", 32'(hresp), 32'h0);
  endtask

  task ledchk(input logic lit);
    logic lv;
    repeat (3) @(negedge hclk);
    lv = lit ^ !led_m[9];
    chk("first", 32'(first_led), (led_m[1:0] == 2'h3) ? 32'(lv) : 32'h0);
    chk("col", 32'(col_led), (led_m[1:0] == 2'h0) ? 32'(lv) : 32'h0);
  endtask

  function automatic logic lit_of(input logic [3:0] c, input logic [7:0] s);
    case (c)
      4'h0: return s[0];
      4'h1: return s[1] | s[2];
      4'h2: return s[1];
      4'h3: return s[2];
      4'h4: return s[3];
      4'h5: return s[0] & s[4];
      4'h6: return s[0] & !s[4];
      4'h7: return s[0] & s[5];
      4'ha: return s[0] & s[4] & s[5];
      4'hb: return s[6];
      4'hc: return s[7];
      default: return 1'h0;
    endcase
  endfunction

  initial begin
    ids = '{`LSCT_IDX_LEDCR, `LSCT_IDX_COMP, `LSCT_IDX_EXT};
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (5) @(posedge hclk);
    bus(1'h0, `LSCT_IDX_LEDCR, 32'h0);
    chk("ledcr", rd, 32'h0);
    bus(1'h0, `LSCT_IDX_COMP, 32'h0);
    chk("comp", rd, 32'h0);
    bus(1'h0, `LSCT_IDX_ERRCNT, 32'h0);
    chk("errreg", rd, 32'h7d);
    for (int i = 0; i < 3; i++) begin
      rnd = $random(seed);
      bus(1'h1, ids[i], rnd);
      bus(1'h0, ids[i], 32'h0);
      chk("rw", rd, {16'h0, rnd[15:0]});
    end
    bus(1'h0, 12'h026, 32'h0);
    chk("unmapped", rd, 32'h0);
    // Every route, reserved ones too; polarity follows route bit 0
    for (int r = 0; r < 4; r++) begin
      for (int c = 0; c < 16; c++) begin
        if (c inside {8, 9, 13, 14})
          continue;
        led_m = {6'h0, 1'(r % 2), 2'h0, 4'(c), 1'h0, 2'(r)};
        bus(1'h1, `LSCT_IDX_LEDCR, {16'h0, led_m});
        repeat (2) begin
          rnd = $random(seed);
          @(posedge hclk);
          stat <= rnd[7:0];
          ledchk(lit_of(4'(c), rnd[7:0]));
        end
      end
    end
    led_m = 16'h026b;
    bus(1'h1, `LSCT_IDX_LEDCR, {16'h0, led_m});
    @(posedge hclk);
    stat <= 8'h1;
    ledchk(1'h0);
    @(posedge hclk);
    stat <= 8'h0;
    ledchk(1'h1);
    @(posedge hclk);
    stat <= 8'h1;
    ledchk(1'h1);
    bus(1'h0, `LSCT_IDX_BASIC, 32'h0);
    ledchk(1'h0);
    led_m = 16'h0273;
    bus(1'h1, `LSCT_IDX_LEDCR, {16'h0, led_m});
    ledchk(1'h0);
    repeat (3) begin
      @(posedge hclk);
      fire <= 1'h1;
      @(posedge hclk);
      fire <= 1'h0;
    end
    ledchk(1'h1);
    bus(1'h1, `LSCT_IDX_ERRCNT, 32'h807d);
    ledchk(1'h0);
    bus(1'h0, `LSCT_IDX_ERRCNT, 32'h0);
    chk("snap", rd, 32'h037d);
    // Stretch: lit while active, then STR cycles more
    led_m = 16'h024b;
    bus(1'h1, `LSCT_IDX_LEDCR, {16'h0, led_m});
    @(posedge hclk);
    stat <= 8'h3;
    @(posedge hclk);
    stat <= 8'h1;
    for (int i = 1; i <= STR + 2; i++) begin
      @(negedge hclk);
      chk("stretch", 32'(first_led), 32'(i <= STR + 1));
    end
    // Blink: half lit under steady activity, steady on when idle
    led_m = 16'h0243;
    bus(1'h1, `LSCT_IDX_LEDCR, {16'h0, led_m});
    @(posedge hclk);
    stat <= 8'h3;
    repeat (2) @(negedge hclk);
    lit_n = 0;
    repeat (4 * BLK) begin
      @(negedge hclk);
      lit_n += first_led;
    end
    chk("blink", lit_n, 2 * BLK);
    @(posedge hclk);
    stat <= 8'h1;
    repeat (STR + 2) @(negedge hclk);
    chk("blink_idle", 32'(first_led), 32'h1);
    @(posedge hclk);
    stat <= 8'h0;
    ledchk(1'h0);
    // Speed forced, no autonegotiation, before any test mode
    bus(1'h1, `LSCT_IDX_BASIC, 32'h2100);
    for (int c = 0; c < 16; c++) begin
      bus(1'h1, `LSCT_IDX_COMP, 32'h10 | c);
      repeat (2) @(negedge hclk);
      chk("tp10_en", 32'(tp10_en), 32'(c <= 12));
      if (c <= 12)
        chk("tp10_sel", 32'(tp10_sel), 32'(c));
    end
    bus(1'h1, `LSCT_IDX_EXT, 32'h0);
    bus(1'h1, `LSCT_IDX_COMP, 32'h7);
    repeat (2) @(negedge hclk);
    chk("tp10_off", 32'(tp10_en), 32'h0);
    chk("tp100_off", 32'(tp100_en), 32'h0);
    bus(1'h1, `LSCT_IDX_EXT, 32'h30);
    repeat (2) @(negedge hclk);
    chk("tp100_en", 32'(tp100_en), 32'h1);
    chk("zeros", 32'(tp100_zeros), 32'h17);
    bus(1'h1, `LSCT_IDX_COMP, 32'h3);
    repeat (2) @(negedge hclk);
    chk("zeros_hold", 32'(tp100_zeros), 32'h17);
    bus(1'h1, `LSCT_IDX_EXT, 32'h20);
    bus(1'h1, `LSCT_IDX_EXT, 32'h30);
    repeat (2) @(negedge hclk);
    chk("zeros_new", 32'(tp100_zeros), 32'h13);
    // Second reset with the strap low: polarity comes up active high
    @(posedge hclk);
    strap <= 1'h0;
    hresetn <= 1'h0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (5) @(posedge hclk);
    bus(1'h0, `LSCT_IDX_LEDCR, 32'h0);
    chk("strap_low", rd, 32'h200);
    bus(1'h0, `LSCT_IDX_COMP, 32'h0);
    chk("comp_rst", rd, 32'h0);
    end_sim();
  end
endmodule
